// >>> rtl/mas_policy_defines.vh
/*
 * Constants for the reservation policy block: zone geometry, run limits,
 * superframe timer lengths and the command port register map.
 * Assumes inclusion by the policy block and by its bench checks.
 */
// Overview of operation
// - Row part: same slots every zone (code: zones 1-15 only)
// - Safe column run limited by start slot
// - Unsafe set only when limit is exceeded
// - Adjacent column blocks merge into one run
// - Release request only to unsafe neighbour (code: a bit 31 forward skips this check)
// - Requested slots lie inside target unsafe (code: a bit 31 forward skips this check)
// - Request carries a valid reason code
// - Release or make safe within 4 superframes
// - Requester holds off unsafe 32 superframes
// - Target holds off until new element/timeout
// - Choose slots for latency or block length
// - Row blocks start as late as possible
// - Column blocks in slots 0-7, else minimal
// - Prefer earliest zone tier
// - Same tier: minimise highest slot
// - Block at earliest free zone position
// - Recheck on change, comply in 32 superframes
// - Unsafe slots exempt from location rules
// - Same rules as owner or target
`ifndef MAS_POLICY_DEFINES_VH
`define MAS_POLICY_DEFINES_VH

`define ZONE_SLOTS          16
`define ZONE_COUNT          16
`define ROW_FIRST_ZONE      1
`define SAFE_SLOT_LAST      4'h7
`define RELEASE_DEADLINE_SF 8'h04
`define REQ_HOLDOFF_SF      8'h20
`define COMPACT_DEADLINE_SF 8'h20
`define LOST_BEACON_LIMIT   8'h04
`define REASON_MAX          4'h7
`define REASON_INVALID      4'hF

`define REG_ZONE_SEL        4'h0
`define REG_ZONE_MAP        4'h1
`define REG_AVAIL           4'h2
`define REG_NEED            4'h3
`define REG_REQ_CMD         4'h4
`define REG_RX_CMD          4'h5
`define REG_STATUS          4'h6
`define REG_RESULT          4'h7
`define REG_UNSAFE          4'h8

`endif

// >>> rtl/mas_reservation_policy.v
/*
 * Reservation policy engine: per-zone unsafe flags from the run limit,
 * release request checks, superframe timers and block placement.
 * Assumes a one-cycle i_sf_tick per superframe and a simple register port
 * whose master never issues read and write together.
 */
`timescale 1ns/1ps
`include "mas_policy_defines.vh"

module mas_reservation_policy #(
    parameter ZONES = `ZONE_COUNT,
    parameter SLOTS = `ZONE_SLOTS
) (
    input  wire        i_clk,
    input  wire        i_sys_rst,
    input  wire        i_sf_tick,
    input  wire [3:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    output reg  [15:0] o_unsafe_zones,
    output reg         o_unsafe_allowed,
    output reg         o_release_pending,
    output reg         o_req_valid,
    output reg  [15:0] o_req_slots,
    output reg  [3:0]  o_req_reason
);

    // Reservation map: one 16-slot word per zone, plus neighbour unsafe map
    reg  [SLOTS-1:0] zone_map_q [0:ZONES-1];
    reg  [SLOTS-1:0] nbr_unsafe_q [0:ZONES-1];
    reg  [3:0]       zone_sel_q;
    reg  [15:0]      avail_q;
    reg  [4:0]       need_len_q;
    reg              need_row_q;
    reg  [7:0]       release_cnt_q;
    reg  [7:0]       req_hold_cnt_q;
    reg  [7:0]       tgt_hold_cnt_q;
    reg  [7:0]       compact_cnt_q;
    reg              tgt_hold_q;
    reg              compact_pending_q;
    reg  [15:0]      rx_slots_q;
    reg  [3:0]       rx_zone_q;
    reg              req_refused_q;
    reg  [3:0]       place_start_q;
    reg              place_ok_q;

    wire [15:0] row_common;
    wire [15:0] zone_unsafe;
    wire        any_unsafe;

    // Longest safe run starting at a given slot
    function [3:0] run_limit;
        input [3:0] first;
        begin
            case (first)
                4'h0: run_limit = 4'h8;
                4'h1: run_limit = 4'h7;
                4'h2: run_limit = 4'h6;
                4'h3: run_limit = 4'h5;
                4'hD: run_limit = 4'h3;
                4'hE: run_limit = 4'h2;
                4'hF: run_limit = 4'h1;
                default: run_limit = 4'h4;
            endcase
        end
    endfunction

    // True when any run of consecutive slots exceeds its start-slot limit
    function exceeds;
        input [15:0] col;
        integer s;
        reg [4:0] len;
        reg [3:0] first;
        reg       bad;
        begin
            len = 5'h00;
            first = 4'h0;
            bad = 1'b0;
            for (s = 0; s < 16; s = s + 1) begin
                if (col[s]) begin
                    if (len == 5'h00)
                        first = s[3:0];
                    len = len + 5'h01;
                    if (len > {1'b0, run_limit(first)})
                        bad = 1'b1;
                end else begin
                    len = 5'h00;
                end
            end
            exceeds = bad;
        end
    endfunction

    // Tier of a zone: 0 for 8, 1 for 0/4/12, 2 for other even, 3 for odd
    function [1:0] zone_tier;
        input [3:0] z;
        begin
            if (z == 4'h8)
                zone_tier = 2'h0;
            else if (z[1:0] == 2'b00)
                zone_tier = 2'h1;
            else if (!z[0])
                zone_tier = 2'h2;
            else
                zone_tier = 2'h3;
        end
    endfunction

    // Row component is the slot set common to every zone past zone zero
    genvar g;
    generate
        for (g = 0; g < ZONES; g = g + 1) begin : g_zone
            wire [15:0] col = zone_map_q[g] & ~row_common;
            assign zone_unsafe[g] = exceeds(col);
            if (g == 0) begin : g_first
                assign row_common = g_fold[ZONES-1].acc;
            end
        end
        for (g = 0; g < ZONES; g = g + 1) begin : g_fold
            wire [15:0] acc;
            if (g < `ROW_FIRST_ZONE) begin : g_skip
                assign acc = 16'hFFFF;
            end else begin : g_and
                assign acc = g_fold[g-1].acc & zone_map_q[g];
            end
        end
    endgenerate

    assign any_unsafe = |zone_unsafe;

    // Placement search over the availability word avail_q for the requested block
    reg  [3:0] best_start;
    reg        best_ok;
    integer    p;
    reg [15:0] win;
    always @* begin
        best_start = 4'h0;
        best_ok = 1'b0;
        win = 16'h0000;
        for (p = 0; p < 16; p = p + 1) begin
            win = (16'hFFFF >> (5'h10 - need_len_q)) << p;
            if (need_len_q != 5'h00 && (p + need_len_q) <= 16 && (win & ~avail_q) == 16'h0000) begin
                if (need_row_q) begin
                    best_start = p[3:0];
                    best_ok = 1'b1;
                end else if (!best_ok) begin
                    best_start = p[3:0];
                    best_ok = 1'b1;
                end
            end
        end
    end

    wire wr_map    = i_wr && (i_addr == `REG_ZONE_MAP);
    wire wr_avail  = i_wr && (i_addr == `REG_AVAIL);
    wire wr_req    = i_wr && (i_addr == `REG_REQ_CMD);
    wire wr_rx     = i_wr && (i_addr == `REG_RX_CMD);
    wire [15:0] nbr_map = nbr_unsafe_q[i_wdata[23:20]];
    wire rx_hits   = (zone_map_q[i_wdata[23:20]] & i_wdata[15:0]) != 16'h0000 && zone_unsafe[i_wdata[23:20]];
    wire req_ok    = (i_wdata[31] || nbr_map != 16'h0000)
                     && (i_wdata[31] || (i_wdata[15:0] & ~nbr_map) == 16'h0000)
                     && i_wdata[19:16] <= `REASON_MAX && i_wdata[15:0] != 16'h0000;
    wire rx_new_elem = wr_rx && i_wdata[30] && tgt_hold_q;
    wire rx_accept   = wr_rx && !i_wdata[30] && rx_hits;
    wire req_accept  = wr_req && req_ok;
    wire [8:0] tgt_holdoff_full = {`LOST_BEACON_LIMIT, 1'b0};
    wire [4:0] place_end = {1'b0, place_start_q} + need_len_q - 5'h01;

    // Next hold-off state, so the permission output drops on the accepting edge
    reg  [7:0] req_hold_cnt_d;
    reg  [7:0] tgt_hold_cnt_d;
    reg        tgt_hold_d;
    always @* begin
        req_hold_cnt_d = req_hold_cnt_q;
        tgt_hold_cnt_d = tgt_hold_cnt_q;
        tgt_hold_d     = tgt_hold_q;
        if (req_accept)
            req_hold_cnt_d = `REQ_HOLDOFF_SF;
        else if (i_sf_tick && req_hold_cnt_q != 8'h00)
            req_hold_cnt_d = req_hold_cnt_q - 8'h01;
        if (rx_accept) begin
            tgt_hold_d     = 1'b1;
            tgt_hold_cnt_d = tgt_holdoff_full[7:0];
        end else if (rx_new_elem) begin
            tgt_hold_d     = 1'b0;
        end else if (i_sf_tick && tgt_hold_q) begin
            if (tgt_hold_cnt_q <= 8'h01)
                tgt_hold_d = 1'b0;
            tgt_hold_cnt_d = tgt_hold_cnt_q - 8'h01;
        end
    end

    integer z;
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (z = 0; z < ZONES; z = z + 1) begin
                zone_map_q[z] <= 16'h0000;
                nbr_unsafe_q[z] <= 16'h0000;
            end
            zone_sel_q <= 4'h0;
            avail_q <= 16'hFFFF;
            need_len_q <= 5'h00;
            need_row_q <= 1'b0;
            release_cnt_q <= 8'h00;
            req_hold_cnt_q <= 8'h00;
            tgt_hold_cnt_q <= 8'h00;
            compact_cnt_q <= 8'h00;
            tgt_hold_q <= 1'b0;
            compact_pending_q <= 1'b0;
            rx_slots_q <= 16'h0000;
            rx_zone_q <= 4'h0;
            req_refused_q <= 1'b0;
            place_start_q <= 4'h0;
            place_ok_q <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_unsafe_zones <= 16'h0000;
            o_unsafe_allowed <= 1'b1;
            o_release_pending <= 1'b0;
            o_req_valid <= 1'b0;
            o_req_slots <= 16'h0000;
            o_req_reason <= 4'h0;
        end else begin
            o_req_valid <= 1'b0;
            if (i_wr && i_addr == `REG_ZONE_SEL)
                zone_sel_q <= i_wdata[3:0];
            if (wr_map) begin
                zone_map_q[zone_sel_q] <= i_wdata[15:0];
                nbr_unsafe_q[zone_sel_q] <= i_wdata[31:16];
            end
            if (i_wr && i_addr == `REG_NEED) begin
                need_len_q <= i_wdata[4:0];
                need_row_q <= i_wdata[8];
            end
            place_start_q <= best_start;
            place_ok_q <= best_ok;
            // Outgoing release request; a forward (bit 31) skips target checks
            if (wr_req) begin
                req_refused_q <= !req_ok;
                if (req_ok) begin
                    o_req_valid <= 1'b1;
                    o_req_slots <= i_wdata[15:0];
                    o_req_reason <= i_wdata[19:16];
                end
            end
            req_hold_cnt_q <= req_hold_cnt_d;
            tgt_hold_q <= tgt_hold_d;
            tgt_hold_cnt_q <= tgt_hold_cnt_d;
            // Received request aimed at us: start deadline and target hold-off
            if (rx_accept) begin
                rx_slots_q <= i_wdata[15:0];
                rx_zone_q <= i_wdata[23:20];
                if (!o_release_pending)
                    release_cnt_q <= `RELEASE_DEADLINE_SF;
                o_release_pending <= 1'b1;
            end else if (o_release_pending) begin
                if (((zone_map_q[rx_zone_q] & rx_slots_q) == 16'h0000) || !zone_unsafe[rx_zone_q]) begin
                    o_release_pending <= 1'b0;
                end else if (i_sf_tick && release_cnt_q != 8'h00) begin
                    release_cnt_q <= release_cnt_q - 8'h01;
                    // Deadline reached without software action: drop the slots
                    if (release_cnt_q == 8'h01) begin
                        zone_map_q[rx_zone_q] <= zone_map_q[rx_zone_q] & ~rx_slots_q;
                        o_release_pending <= 1'b0;
                    end
                end
            end
            // Availability change triggers a compaction window
            if (wr_avail)
                avail_q <= i_wdata[15:0];
            if (wr_avail && i_wdata[15:0] != avail_q) begin
                compact_pending_q <= 1'b1;
                compact_cnt_q <= `COMPACT_DEADLINE_SF;
            end else if (compact_pending_q) begin
                if (place_ok_q && (zone_map_q[zone_sel_q] & ~avail_q & ~{16{zone_unsafe[zone_sel_q]}}) == 16'h0000)
                    compact_pending_q <= 1'b0;
                else if (i_sf_tick && compact_cnt_q != 8'h00)
                    compact_cnt_q <= compact_cnt_q - 8'h01;
            end
            o_unsafe_zones <= zone_unsafe;
            o_unsafe_allowed <= (req_hold_cnt_d == 8'h00) && !tgt_hold_d;
            if (i_rd) begin
                case (i_addr)
                    `REG_ZONE_SEL: o_rdata <= {28'h0000000, zone_sel_q};
                    `REG_ZONE_MAP: o_rdata <= {nbr_unsafe_q[zone_sel_q], zone_map_q[zone_sel_q]};
                    `REG_AVAIL:    o_rdata <= {16'h0000, avail_q};
                    `REG_NEED:     o_rdata <= {23'h000000, need_row_q, 3'h0, need_len_q};
                    `REG_STATUS:   o_rdata <= {8'h00, compact_cnt_q, release_cnt_q, 3'h0, req_refused_q,
                                              compact_pending_q, tgt_hold_q, (req_hold_cnt_q != 8'h00),
                                              o_release_pending};
                    // Tier of selected zone ranks it among placement candidates
                    `REG_RESULT:   o_rdata <= {24'h000000, zone_tier(zone_sel_q), place_ok_q,
                                              (place_end <= {1'b0, `SAFE_SLOT_LAST}),
                                              place_start_q};
                    `REG_UNSAFE:   o_rdata <= {15'h0000, any_unsafe, zone_unsafe};
                    default:       o_rdata <= 32'h0000_0000;
                endcase
            end else begin
                o_rdata <= 32'h0000_0000;
            end
        end
    end

endmodule // mas_reservation_policy

// >>> bench/mas_policy_properties.sv
/* Concurrent checks on the reservation policy ports.
   Assumes the register map and limits of mas_policy_defines.vh. */
`timescale 1ns/1ps
`include "mas_policy_defines.vh"
module mas_policy_properties #(
    parameter ZONES = 16,
    parameter SLOTS = 16
) (
    input wire        i_clk,
    input wire        i_sys_rst,
    input wire        i_sf_tick,
    input wire [3:0]  i_addr,
    input wire [31:0] i_wdata,
    input wire        i_wr,
    input wire        i_rd,
    input wire [31:0] o_rdata,
    input wire [15:0] o_unsafe_zones,
    input wire        o_unsafe_allowed,
    input wire        o_release_pending,
    input wire        o_req_valid,
    input wire [15:0] o_req_slots,
    input wire [3:0]  o_req_reason
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence bad_reason_wr;
        i_wr && i_addr == `REG_REQ_CMD && i_wdata[19:16] > `REASON_MAX;
    endsequence
    sequence held_off;
        !o_unsafe_allowed && !i_sf_tick && !i_wr;
    endsequence
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside its cycle");
    req_cause_a: assert property (o_req_valid |-> $past(i_wr && i_addr == `REG_REQ_CMD))
        else $error("request pulse without command");
    req_reason_a: assert property (o_req_valid |-> o_req_reason <= `REASON_MAX)
        else $error("request reason out of range");
    bad_reason_a: assert property (bad_reason_wr |=> !o_req_valid)
        else $error("bad reason accepted");
    req_slots_a: assert property (o_req_valid |-> o_req_slots != 16'h0)
        else $error("request names no slot");
    req_hold_a: assert property (o_req_valid |-> !o_unsafe_allowed)
        else $error("hold-off missing after request");
    hold_tick_a: assert property (held_off |=> !o_unsafe_allowed)
        else $error("hold-off ended without tick");
    unsafe_cause_a: assert property ((o_unsafe_zones & ~$past(o_unsafe_zones)) != 16'h0
        |-> $past(i_wr && i_addr == `REG_ZONE_MAP, 2) && $past(o_unsafe_allowed)) else $error("unsafe bit without cause");
    pend_cause_a: assert property ($rose(o_release_pending) |-> $past(i_wr && i_addr == `REG_RX_CMD))
        else $error("pending without release command");
    slots_keep_a: assert property (!o_req_valid |-> $stable(o_req_slots))
        else $error("request slots changed");
endmodule // mas_policy_properties

bind mas_reservation_policy mas_policy_properties #(.ZONES(ZONES), .SLOTS(SLOTS)) props (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sf_tick(i_sf_tick), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_unsafe_zones(o_unsafe_zones),
    .o_unsafe_allowed(o_unsafe_allowed), .o_release_pending(o_release_pending),
    .o_req_valid(o_req_valid), .o_req_slots(o_req_slots), .o_req_reason(o_req_reason));

// >>> bench/neighbour_mac.sv
/* Neighbour model: paces the superframes that all policy timers count.
   Assumes a free-running MAC clock and active-high asynchronous reset. */
`timescale 1ns/1ps
module neighbour_mac #(
    parameter SF_CYCLES = 16
) (
    input  wire i_clk,
    input  wire i_sys_rst,
    output reg  o_sf_tick
);
    reg [7:0] cnt_q;
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q     <= 8'h00;
            o_sf_tick <= 1'b0;
        end else begin
            cnt_q     <= (cnt_q == SF_CYCLES - 1) ? 8'h00 : cnt_q + 8'h01;
            o_sf_tick <= (cnt_q == SF_CYCLES - 1);
        end
    end
endmodule // neighbour_mac

// >>> bench/mas_reservation_policy_test.sv
/* Register-level bench of the reservation policy block.
   Assumes neighbour_mac supplies the superframe tick. */
`timescale 1ns/1ps
`include "mas_policy_defines.vh"
module mas_reservation_policy_test;
    localparam [111:0] MAPS = {16'h8000, 16'hE000, 16'hC000, 16'h00F0, 16'h01F0, 16'h00FF, 16'h01FF};
    reg         i_clk     = 1'b0;
    reg         i_sys_rst = 1'b1;
    reg  [3:0]  i_addr    = 4'h0;
    reg  [31:0] i_wdata   = 32'h0;
    reg         i_wr      = 1'b0;
    reg         i_rd      = 1'b0;
    wire        i_sf_tick;
    wire [31:0] o_rdata;
    wire [15:0] o_unsafe_zones;
    wire [15:0] o_req_slots;
    wire [3:0]  o_req_reason;
    wire        o_unsafe_allowed;
    wire        o_release_pending;
    wire        o_req_valid;
    integer     failures = 0;
    integer     compares = 0;
    integer     z;
    reg  [31:0] rv;
    always #5 i_clk = ~i_clk;
    neighbour_mac nbr (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_sf_tick(i_sf_tick));
    mas_reservation_policy dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sf_tick(i_sf_tick), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_unsafe_zones(o_unsafe_zones),
        .o_unsafe_allowed(o_unsafe_allowed), .o_release_pending(o_release_pending), .o_req_valid(o_req_valid),
        .o_req_slots(o_req_slots), .o_req_reason(o_req_reason));
    task give_verdict;
        begin
            if (failures == 0 && compares > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge i_clk);
            i_addr  <= a;
            i_wdata <= d;
            i_wr    <= 1'b1;
            @(posedge i_clk);
            i_wr    <= 1'b0;
            #1;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge i_clk);
            i_addr <= a;
            i_rd   <= 1'b1;
            @(posedge i_clk);
            i_rd   <= 1'b0;
            #1 rv = o_rdata;
        end
    endtask
    task ticks(input integer n);
        integer k, t;
        begin
            k = 0;
            t = 0;
            while (k < n && t < 40 * n) begin
                @(posedge i_clk);
                if (i_sf_tick === 1'b1)
                    k = k + 1;
                t = t + 1;
            end
            if (k < n) begin
                failures = failures + 1;
                $display("[FAIL] %0t superframe tick missing", $time);
                give_verdict;
            end else begin
                @(posedge i_clk);
                #1;
            end
        end
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        #1 chk({o_unsafe_zones, o_unsafe_allowed, o_release_pending, o_req_valid}, 32'h4);
        for (z = 0; z < 7; z = z + 1) begin
            wr(`REG_ZONE_SEL, z);
            wr(`REG_ZONE_MAP, {16'h00F0, MAPS[16 * z +: 16]});
        end
        repeat (2) @(posedge i_clk);
        #1 chk(o_unsafe_zones, 32'h5);
        rd(`REG_UNSAFE);
        chk(rv, 32'h00010005);
        wr(`REG_REQ_CMD, 32'h00330030);
        chk({o_req_valid, o_unsafe_allowed, o_req_reason, o_req_slots}, 32'h00230030);
        wr(`REG_REQ_CMD, 32'h00380030);
        chk(o_req_valid, 32'h0);
        wr(`REG_REQ_CMD, 32'h00330100);
        chk(o_req_valid, 32'h0);
        wr(`REG_REQ_CMD, 32'h00330000);
        chk(o_req_valid, 32'h0);
        rd(`REG_STATUS);
        chk(rv[4] & rv[1], 32'h1);
        ticks(`REQ_HOLDOFF_SF - 1);
        chk(o_unsafe_allowed, 32'h0);
        ticks(2);
        chk(o_unsafe_allowed, 32'h1);
        wr(`REG_RX_CMD, 32'h00000100);
        @(posedge i_clk);
        #1 chk({o_release_pending, o_unsafe_allowed}, 32'h2);
        ticks(5);
        chk({o_release_pending, o_unsafe_allowed, o_unsafe_zones[0]}, 32'h0);
        wr(`REG_RX_CMD, 32'h00000100);
        wr(`REG_RX_CMD, 32'h40000000);
        repeat (2) @(posedge i_clk);
        #1 chk({o_release_pending, o_unsafe_allowed}, 32'h1);
        wr(`REG_RX_CMD, 32'h00200010);
        wr(`REG_ZONE_SEL, 32'h2);
        wr(`REG_ZONE_MAP, 32'h00F000F0);
        @(posedge i_clk);
        #1 chk({o_release_pending, o_unsafe_allowed, o_unsafe_zones[2]}, 32'h0);
        ticks(2 * `LOST_BEACON_LIMIT - 1);
        chk(o_unsafe_allowed, 32'h0);
        ticks(1);
        chk(o_unsafe_allowed, 32'h1);
        wr(`REG_AVAIL, 32'h0000FF0F);
        wr(`REG_NEED, 32'h00000003);
        rd(`REG_RESULT);
        chk(rv, 32'hB0);
        rd(`REG_STATUS);
        chk(rv[3], 32'h1);
        wr(`REG_NEED, 32'h00000103);
        rd(`REG_RESULT);
        chk(rv, 32'hAD);
        wr(`REG_AVAIL, 32'h0000FFFF);
        rd(`REG_STATUS);
        chk(rv[3], 32'h0);
        give_verdict;
    end
endmodule // mas_reservation_policy_test
